// ### src/tocs_pkg.sv
// constants and types for transmitter output conditioning select
package tocs_pkg;
    // ----------------------------------------
    // geometry and register map
    // ----------------------------------------
    localparam int unsigned TOCS_LANES      = 4;
    localparam int unsigned TOCS_ADDR_W     = 8;
    localparam int unsigned TOCS_CLK_LANE   = 3;
    localparam logic [7:0]  ADDR_CTRL       = 8'h00;
    localparam logic [7:0]  ADDR_SLEW       = 8'h04;
    localparam logic [7:0]  ADDR_SWG14      = 8'h08;
    localparam logic [7:0]  ADDR_SWG20      = 8'h0C;
    localparam logic [7:0]  ADDR_LIN        = 8'h10;
    localparam logic [7:0]  ADDR_STAT       = 8'h14;
    localparam int unsigned CTRL_SNOOP_BIT  = 0;
    localparam int unsigned CTRL_SPLIT_BIT  = 1;
    localparam int unsigned CTRL_LINEAR_BIT = 2;
    localparam int unsigned CTRL_SWAP_BIT   = 3;
    localparam int unsigned CTRL_EMPH_LSB   = 4;
    localparam int unsigned SLEW_CLK_LSB    = 0;
    localparam int unsigned SLEW_LOW_LSB    = 4;
    localparam int unsigned SLEW_MID_LSB    = 8;
    localparam int unsigned SLEW_HIGH_LSB   = 12;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;
    localparam logic [31:0] SLEW_RESET      = 32'h0000_7320;
    localparam logic [31:0] SWG_RESET       = 32'h0000_8888;
    localparam logic [31:0] LIN_RESET       = 32'h0000_0003;
    localparam logic [31:0] CTRL_MASK       = 32'h0000_007F;
    localparam logic [31:0] SLEW_MASK       = 32'h0000_7777;
    localparam logic [31:0] SWG_MASK        = 32'h0000_FFFF;
    localparam logic [31:0] LIN_MASK        = 32'h0000_0003;
    // ----------------------------------------
    // snoop offsets and link codes
    // ----------------------------------------
    localparam logic [7:0]  SNOOP_OFS_RATIO = 8'h20;
    localparam int unsigned RATIO_BIT       = 1;
    localparam logic [7:0]  SNOOP_OFS_RATE  = 8'h31;
    localparam logic [3:0]  FRL_RATE_NONE   = 4'h0;
    localparam logic [3:0]  FRL_RATE_3G     = 4'h1;
    localparam logic [3:0]  FRL_RATE_6G_A   = 4'h2;
    localparam logic [3:0]  FRL_RATE_6G_B   = 4'h3;
    // ----------------------------------------
    // output codes
    // ----------------------------------------
    localparam logic [2:0]  EDGE_FIXED      = 3'h0;
    localparam logic [3:0]  SWING_DEFAULT   = 4'h8;
    localparam logic [3:0]  SWING_MINUS5    = 4'h7;
    localparam logic [3:0]  SWING_PLUS5     = 4'h9;
    localparam logic [3:0]  SWING_PLUS10    = 4'hA;
    localparam logic [1:0]  LIN_MAX         = 2'h3;

    typedef enum logic [1:0] {
        LVL_LOW   = 2'b00,
        LVL_RES   = 2'b01,
        LVL_FLOAT = 2'b10,
        LVL_HIGH  = 2'b11
    } tocs_level_t;

    typedef enum logic [1:0] {
        MODE_STRAP_FIXED = 2'b00,
        MODE_STRAP_FLEX  = 2'b01,
        MODE_STRAP_SPLIT = 2'b10,
        MODE_REGISTER    = 2'b11
    } tocs_mode_t;

    typedef enum logic [1:0] {
        GEN_14  = 2'b00,
        GEN_20  = 2'b01,
        GEN_FRL = 2'b10
    } tocs_gen_t;

    typedef enum logic [2:0] {
        EMPH_0DB = 3'b000,
        PRE_3P5  = 3'b001,
        PRE_6P0  = 3'b010,
        DE_2P5   = 3'b011,
        DE_3P5   = 3'b100,
        DE_3P7   = 3'b101,
        DE_4P6   = 3'b110
    } tocs_emph_t;

    typedef struct packed {
        tocs_mode_t                       op_mode;
        tocs_gen_t                        link_gen;
        logic                             snoop_active;
        logic                             edge_rate_en;
        logic [2:0]                       edge_rate_clk;
        logic [2:0]                       edge_rate_data;
        tocs_emph_t                       emph_data;
        tocs_emph_t                       emph_clk;
        logic [TOCS_LANES-1:0][3:0]       lane_swing;
        logic [1:0]                       lin_range;
        logic                             ref_clk_en;
        logic                             main_clk_en;
        logic                             clk_lane_data3;
    } tocs_cfg_t;

    typedef struct packed {
        tocs_level_t mode_lvl;
        tocs_level_t emph_lvl;
        tocs_level_t swing_lvl;
        logic        linear_pin;
        logic        swap_pin;
        logic        strap_done;
        logic        clk_ratio;
        logic [3:0]  frl_rate;
        logic [31:0] ctrl;
        logic [31:0] slew;
        logic [31:0] swg14;
        logic [31:0] swg20;
        logic [31:0] lin;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        tocs_cfg_t   cfg;
    } tocs_state_t;
endpackage

// ### src/tocs_select.sv
// output conditioning selection with apb register slave
// How it works
// - strap mode keeps edge rate fixed
// - register mode takes edge rates from registers
// - edge rate only acts when limited driver
// - clock lane emphasis only in frl
// - emphasis only as limited driver
// - emphasis strap picks global data emphasis
// - frl de-emphasis from snooped equalizer level
// - register swing held per lane
// - separate swing registers for 1.4 and for 2.0/frl
// - swing strap adjusts default, clock lane rules
// - swing strap decode per generation
// - strap linear fixes range, ignores swing
// - register mode linearity range from register
// - split in 1.4/2.0 moves clock out
// - split in frl sends lane 3 on clock
// - split enabled by strap or register bit
// - lane swap forces split off
// - mode strap decodes four modes
// - snoop on in strap, register gated
// - snooped settings set link generation
// - power down returns generation to 1.4
// - float mode strap means register mode
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ns
module tocs_select #(
    parameter int unsigned LANES = 4
) (
    // clock and reset
    input  wire logic                            clk_sys,
    input  wire logic                            rst,
    // apb slave
    input  wire logic [tocs_pkg::TOCS_ADDR_W-1:0] paddr,
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [31:0]                     pwdata,
    input  wire logic [3:0]                      pstrb,
    output logic      [31:0]                     prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    // strap pins
    input  wire tocs_pkg::tocs_level_t           mode_strap,
    input  wire tocs_pkg::tocs_level_t           emphasis_strap,
    input  wire tocs_pkg::tocs_level_t           swing_strap,
    input  wire logic                            linear_strap,
    input  wire logic                            swap_strap,
    // display channel snoop
    input  wire logic                            snoop_wr,
    input  wire logic [7:0]                      snoop_offset,
    input  wire logic [7:0]                      snoop_data,
    input  wire logic [1:0]                      snooped_tx_equalizer_level,
    input  wire logic                            power_down,
    // conditioning outputs
    output tocs_pkg::tocs_cfg_t                  lane_cfg
);
    import tocs_pkg::*;

    tocs_state_t s_r;
    tocs_state_t s_nxt;

    // ----------------------------------------
    // elaboration check
    // ----------------------------------------
    if (LANES != TOCS_LANES) begin : g_bad_lanes
        $error("tocs_select serves exactly four lanes");
    end

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function automatic tocs_mode_t mode_decode(input tocs_level_t lvl);
        tocs_mode_t m;
        case (lvl)
            LVL_LOW:   m = MODE_STRAP_FIXED;
            LVL_HIGH:  m = MODE_STRAP_FLEX;
            LVL_RES:   m = MODE_STRAP_SPLIT;
            LVL_FLOAT: m = MODE_REGISTER;
            default:   m = MODE_REGISTER;
        endcase
        return m;
    endfunction

    function automatic logic [3:0] swing_decode(input tocs_level_t lvl, input tocs_gen_t g);
        logic [3:0] v;
        case (lvl)
            LVL_LOW:   v = (g == GEN_FRL) ? SWING_PLUS10 : SWING_DEFAULT;
            LVL_RES:   v = SWING_MINUS5;
            LVL_FLOAT: v = SWING_DEFAULT;
            LVL_HIGH:  v = (g == GEN_14) ? SWING_DEFAULT : SWING_PLUS5;
            default:   v = SWING_DEFAULT;
        endcase
        return v;
    endfunction

    function automatic tocs_emph_t emph_decode(input tocs_level_t lvl);
        tocs_emph_t e;
        case (lvl)
            LVL_LOW:   e = PRE_3P5;
            LVL_RES:   e = DE_2P5;
            LVL_FLOAT: e = EMPH_0DB;
            LVL_HIGH:  e = PRE_6P0;
            default:   e = EMPH_0DB;
        endcase
        return e;
    endfunction

    function automatic tocs_emph_t ffe_decode(input logic [1:0] lvl);
        tocs_emph_t e;
        case (lvl)
            2'h0:    e = DE_2P5;
            2'h1:    e = DE_3P5;
            2'h2:    e = DE_3P7;
            2'h3:    e = DE_4P6;
            default: e = DE_2P5;
        endcase
        return e;
    endfunction

    function automatic logic reg_hit(input logic [TOCS_ADDR_W-1:0] a);
        return (a == ADDR_CTRL) || (a == ADDR_SLEW) || (a == ADDR_SWG14) ||
               (a == ADDR_SWG20) || (a == ADDR_LIN) || (a == ADDR_STAT);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] bm;
        bm = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return ((old & ~bm) | (wd & bm)) & mask;
    endfunction

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        tocs_mode_t  mode;
        tocs_gen_t   gen;
        logic        reg_mode;
        logic        limited;
        logic        swap;
        logic        split;
        logic        snoop_on;
        logic [2:0]  data_edge;
        logic [31:0] swg;
        logic [3:0]  strap_swing;
        logic [31:0] rd;
        mode        = mode_decode(s_r.mode_lvl);
        reg_mode    = 1'b0;
        limited     = 1'b0;
        swap        = 1'b0;
        split       = 1'b0;
        snoop_on    = 1'b0;
        gen         = GEN_14;
        data_edge   = EDGE_FIXED;
        swg         = 32'h0000_0000;
        strap_swing = SWING_DEFAULT;
        rd          = 32'h0000_0000;
        s_nxt       = s_r;

        // strap capture on first cycle after reset
        if (!s_r.strap_done) begin
            s_nxt.mode_lvl   = mode_strap;
            s_nxt.emph_lvl   = emphasis_strap;
            s_nxt.swing_lvl  = swing_strap;
            s_nxt.linear_pin = linear_strap;
            s_nxt.swap_pin   = swap_strap;
            s_nxt.strap_done = 1'b1;
        end

        reg_mode = (mode == MODE_REGISTER);
        limited  = reg_mode ? ~s_r.ctrl[CTRL_LINEAR_BIT] : ~s_r.linear_pin;
        swap     = reg_mode ? s_r.ctrl[CTRL_SWAP_BIT] : s_r.swap_pin;
        split    = ((mode == MODE_STRAP_SPLIT) ||
                    (reg_mode && s_r.ctrl[CTRL_SPLIT_BIT])) && !swap;
        snoop_on = !reg_mode || s_r.ctrl[CTRL_SNOOP_BIT];
        if (s_r.frl_rate != FRL_RATE_NONE) begin
            gen = GEN_FRL;
        end else if (s_r.clk_ratio) begin
            gen = GEN_20;
        end else begin
            gen = GEN_14;
        end

        // apb read mux and handshake
        case (paddr)
            ADDR_CTRL:  rd = s_r.ctrl;
            ADDR_SLEW:  rd = s_r.slew;
            ADDR_SWG14: rd = s_r.swg14;
            ADDR_SWG20: rd = s_r.swg20;
            ADDR_LIN:   rd = s_r.lin;
            ADDR_STAT:  rd = {26'h000_0000, s_r.cfg.snoop_active, s_r.cfg.ref_clk_en,
                              s_r.cfg.op_mode, s_r.cfg.link_gen};
            default:    rd = 32'h0000_0000;
        endcase
        s_nxt.pready  = 1'b0;
        s_nxt.pslverr = 1'b0;
        if (psel && !penable && !s_r.pready) begin
            s_nxt.pready  = 1'b1;
            s_nxt.pslverr = !reg_hit(paddr);
            s_nxt.prdata  = pwrite ? 32'h0000_0000 : rd;
        end
        if (psel && penable && s_r.pready && pwrite) begin
            case (paddr)
                ADDR_CTRL:  s_nxt.ctrl  = merge(s_r.ctrl, pwdata, pstrb, CTRL_MASK);
                ADDR_SLEW:  s_nxt.slew  = merge(s_r.slew, pwdata, pstrb, SLEW_MASK);
                ADDR_SWG14: s_nxt.swg14 = merge(s_r.swg14, pwdata, pstrb, SWG_MASK);
                ADDR_SWG20: s_nxt.swg20 = merge(s_r.swg20, pwdata, pstrb, SWG_MASK);
                ADDR_LIN:   s_nxt.lin   = merge(s_r.lin, pwdata, pstrb, LIN_MASK);
                default:    s_nxt.ctrl  = s_r.ctrl;
            endcase
        end

        // snooped sink settings
        if (power_down) begin
            s_nxt.clk_ratio = 1'b0;
            s_nxt.frl_rate  = FRL_RATE_NONE;
        end else if (snoop_on && snoop_wr) begin
            if (snoop_offset == SNOOP_OFS_RATIO) begin
                s_nxt.clk_ratio = snoop_data[RATIO_BIT];
            end
            if (snoop_offset == SNOOP_OFS_RATE) begin
                s_nxt.frl_rate = snoop_data[3:0];
            end
        end

        // edge rate selection
        if (reg_mode) begin
            if (gen == GEN_14 || s_r.frl_rate == FRL_RATE_3G) begin
                data_edge = s_r.slew[SLEW_LOW_LSB +: 3];
            end else if (gen == GEN_20 || s_r.frl_rate == FRL_RATE_6G_A ||
                         s_r.frl_rate == FRL_RATE_6G_B) begin
                data_edge = s_r.slew[SLEW_MID_LSB +: 3];
            end else begin
                data_edge = s_r.slew[SLEW_HIGH_LSB +: 3];
            end
            s_nxt.cfg.edge_rate_data = data_edge;
            s_nxt.cfg.edge_rate_clk  = (gen == GEN_FRL) ? data_edge
                                                        : s_r.slew[SLEW_CLK_LSB +: 3];
        end else begin
            s_nxt.cfg.edge_rate_data = EDGE_FIXED;
            s_nxt.cfg.edge_rate_clk  = EDGE_FIXED;
        end
        s_nxt.cfg.edge_rate_en = limited;

        // emphasis selection
        if (!limited) begin
            s_nxt.cfg.emph_data = EMPH_0DB;
        end else if (gen == GEN_FRL) begin
            s_nxt.cfg.emph_data = ffe_decode(snooped_tx_equalizer_level);
        end else if (reg_mode) begin
            s_nxt.cfg.emph_data = tocs_emph_t'(s_r.ctrl[CTRL_EMPH_LSB +: 3]);
        end else begin
            s_nxt.cfg.emph_data = emph_decode(s_r.emph_lvl);
        end
        s_nxt.cfg.emph_clk = (gen == GEN_FRL) ? s_nxt.cfg.emph_data : EMPH_0DB;

        // swing and linearity selection
        swg         = (gen == GEN_14) ? s_r.swg14 : s_r.swg20;
        strap_swing = swing_decode(s_r.swing_lvl, gen);
        for (int i = 0; i < TOCS_LANES; i++) begin
            if (reg_mode) begin
                s_nxt.cfg.lane_swing[i] = swg[4*i +: 4];
            end else if (!limited) begin
                s_nxt.cfg.lane_swing[i] = SWING_DEFAULT;
            end else if (i == TOCS_CLK_LANE && gen == GEN_20) begin
                s_nxt.cfg.lane_swing[i] = SWING_DEFAULT;
            end else begin
                s_nxt.cfg.lane_swing[i] = strap_swing;
            end
        end
        s_nxt.cfg.lin_range = reg_mode ? s_r.lin[1:0] : LIN_MAX;

        // clock lane routing
        s_nxt.cfg.ref_clk_en     = split && (gen != GEN_FRL);
        s_nxt.cfg.main_clk_en    = !(split && (gen != GEN_FRL));
        s_nxt.cfg.clk_lane_data3 = split && (gen == GEN_FRL);
        s_nxt.cfg.op_mode        = mode;
        s_nxt.cfg.link_gen       = gen;
        s_nxt.cfg.snoop_active   = snoop_on;
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_r <= '{mode_lvl: LVL_FLOAT, emph_lvl: LVL_FLOAT, swing_lvl: LVL_FLOAT,
                     linear_pin: 1'b0, swap_pin: 1'b0, strap_done: 1'b0,
                     clk_ratio: 1'b0, frl_rate: FRL_RATE_NONE, ctrl: CTRL_RESET,
                     slew: SLEW_RESET, swg14: SWG_RESET, swg20: SWG_RESET,
                     lin: LIN_RESET, pready: 1'b0, pslverr: 1'b0,
                     prdata: 32'h0000_0000,
                     cfg: '{op_mode: MODE_REGISTER, link_gen: GEN_14,
                            snoop_active: 1'b1, edge_rate_en: 1'b1,
                            edge_rate_clk: EDGE_FIXED, edge_rate_data: EDGE_FIXED,
                            emph_data: EMPH_0DB, emph_clk: EMPH_0DB,
                            lane_swing: {TOCS_LANES{SWING_DEFAULT}},
                            lin_range: LIN_MAX, ref_clk_en: 1'b0,
                            main_clk_en: 1'b1, clk_lane_data3: 1'b0}};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign prdata   = s_r.prdata;
    assign pready   = s_r.pready;
    assign pslverr  = s_r.pslverr;
    assign lane_cfg = s_r.cfg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_strap_edge_fixed: assert property (
        lane_cfg.op_mode != MODE_REGISTER |->
            lane_cfg.edge_rate_clk == EDGE_FIXED && lane_cfg.edge_rate_data == EDGE_FIXED)
        else $error("strap mode edge rate moved");
    a_reg_edge_clk: assert property (
        lane_cfg.op_mode == MODE_REGISTER && lane_cfg.link_gen == GEN_20 |->
            lane_cfg.edge_rate_clk == $past(s_r.slew[SLEW_CLK_LSB +: 3]) &&
            lane_cfg.edge_rate_data == $past(s_r.slew[SLEW_MID_LSB +: 3]))
        else $error("register edge rate not applied");
    a_clk_emph_off: assert property (
        lane_cfg.link_gen != GEN_FRL |-> lane_cfg.emph_clk == EMPH_0DB)
        else $error("clock lane emphasis outside frl");
    a_linear_no_emph: assert property (
        !lane_cfg.edge_rate_en |->
            lane_cfg.emph_data == EMPH_0DB && lane_cfg.emph_clk == EMPH_0DB)
        else $error("emphasis in linear driver");
    a_frl_deemph_map: assert property (
        lane_cfg.edge_rate_en && lane_cfg.link_gen == GEN_FRL &&
        $past(snooped_tx_equalizer_level) == 2'h3 |-> lane_cfg.emph_data == DE_4P6)
        else $error("frl de-emphasis mismatch");
    a_strap_lin_max: assert property (
        lane_cfg.op_mode != MODE_REGISTER |-> lane_cfg.lin_range == LIN_MAX)
        else $error("strap linearity range not max");
    a_split_routing: assert property (
        lane_cfg.ref_clk_en |-> !lane_cfg.main_clk_en && lane_cfg.link_gen != GEN_FRL)
        else $error("reference clock with main clock");
    a_frl_lane3: assert property (
        lane_cfg.clk_lane_data3 |-> lane_cfg.main_clk_en && !lane_cfg.ref_clk_en)
        else $error("frl split routing wrong");
    a_swap_kills_split: assert property (
        $past(s_r.swap_pin) && lane_cfg.op_mode == MODE_STRAP_SPLIT |->
            !lane_cfg.ref_clk_en && !lane_cfg.clk_lane_data3)
        else $error("split active under swap");
    a_snoop_strap_on: assert property (
        lane_cfg.op_mode != MODE_REGISTER |-> lane_cfg.snoop_active)
        else $error("snoop off in strap mode");
    a_pd_gen_reset: assert property (
        power_down |-> ##2 lane_cfg.link_gen == GEN_14)
        else $error("generation kept over power down");
    a_apb_ready: assert property (
        psel && !penable && !pready |=> pready ##1 !pready)
        else $error("apb ready not one cycle");
endmodule

// ### verification/tocs_sink_model.sv
// sink-side model issuing snooped configuration writes
`timescale 1ns/1ns
module tocs_sink_model (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // request from bench
    input  wire logic       go,
    input  wire logic [7:0] ofs,
    input  wire logic [7:0] dat,
    // snoop channel
    output logic            snoop_wr,
    output logic [7:0]      snoop_offset,
    output logic [7:0]      snoop_data
);
    // idle offset and data lines toggle so no stale value is seen
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            snoop_wr     <= 1'b0;
            snoop_offset <= 8'h00;
            snoop_data   <= 8'h00;
        end else begin
            snoop_wr     <= go;
            snoop_offset <= go ? ofs : ~snoop_offset;
            snoop_data   <= go ? dat : ~snoop_data;
        end
    end
endmodule

// ### verification/tb_tx_output_conditioning_select.sv
// bench for output conditioning selection
`timescale 1ns/1ns
module tb_tx_output_conditioning_select;
    import tocs_pkg::*;
    typedef struct packed {
        tocs_level_t m, e, s;
        logic        lin, swp, g20;
        tocs_emph_t  xe;
        logic [3:0]  xd, xc;
        logic        xr, xm;
    } tocs_row_t;
    localparam tocs_row_t ROWS [7] = '{
        '{LVL_LOW, LVL_LOW, LVL_RES, 0, 0, 0, PRE_3P5, 7, 7, 0, 1},
        '{LVL_LOW, LVL_RES, LVL_HIGH, 0, 0, 0, DE_2P5, 8, 8, 0, 1},
        '{LVL_HIGH, LVL_FLOAT, LVL_LOW, 0, 0, 1, EMPH_0DB, 8, 8, 0, 1},
        '{LVL_HIGH, LVL_HIGH, LVL_HIGH, 0, 0, 1, PRE_6P0, 9, 8, 0, 1},
        '{LVL_HIGH, LVL_LOW, LVL_RES, 0, 0, 1, PRE_3P5, 7, 8, 0, 1},
        '{LVL_RES, LVL_HIGH, LVL_RES, 1, 0, 0, EMPH_0DB, 8, 8, 1, 0},
        '{LVL_RES, LVL_LOW, LVL_FLOAT, 0, 1, 0, PRE_3P5, 8, 8, 0, 1}};
    logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, ls, sw, pd, go, swr;
    logic [7:0]  paddr, ofs, dat, sofs, sdat;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  eq;
    logic        er;
    tocs_level_t ms, es, ss;
    tocs_cfg_t   c;
    int          bad_count, cmp_count;
    tocs_select dut (.clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode_strap(ms),
        .emphasis_strap(es), .swing_strap(ss), .linear_strap(ls), .swap_strap(sw),
        .snoop_wr(swr), .snoop_offset(sofs), .snoop_data(sdat),
        .snooped_tx_equalizer_level(eq), .power_down(pd), .lane_cfg(c));
    tocs_sink_model sink (.clk_sys(clk_sys), .rst(rst), .go(go), .ofs(ofs), .dat(dat),
        .snoop_wr(swr), .snoop_offset(sofs), .snoop_data(sdat));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic snoop(input logic [7:0] o, input logic [7:0] d);
        @(posedge clk_sys);
        go <= 1'b1; ofs <= o; dat <= d;
        @(posedge clk_sys);
        go <= 1'b0;
        wt(4);
    endtask
    task automatic do_reset;
        rst <= 1'b1;
        wt(6);
        rst <= 1'b0;
        wt(4);
    endtask
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ----------------------------------------
    // stimulus
    // ----------------------------------------
    initial begin
        clk_sys = 0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        wt(20000);
        bad_count++;
        give_verdict();
    end
    initial begin
        {rst, psel, penable, pwrite, ls, sw, pd, go, eq} = 10'h200;
        {paddr, ofs, dat, pwdata} = 56'h0;
        ms = LVL_FLOAT;
        es = LVL_FLOAT;
        ss = LVL_FLOAT;
        foreach (ROWS[i]) begin
            ms <= ROWS[i].m; es <= ROWS[i].e; ss <= ROWS[i].s;
            ls <= ROWS[i].lin; sw <= ROWS[i].swp;
            do_reset();
            if (ROWS[i].g20) snoop(SNOOP_OFS_RATIO, 8'h02);
            chk(c.op_mode, ROWS[i].m == LVL_LOW ? MODE_STRAP_FIXED :
                ROWS[i].m == LVL_RES ? MODE_STRAP_SPLIT : MODE_STRAP_FLEX);
            chk(c.emph_data, ROWS[i].xe);
            chk(c.emph_clk, EMPH_0DB);
            chk(c.lane_swing[0], ROWS[i].xd);
            chk(c.lane_swing[3], ROWS[i].xc);
            chk({c.edge_rate_clk, c.edge_rate_data}, {EDGE_FIXED, EDGE_FIXED});
            chk({c.ref_clk_en, c.main_clk_en}, {ROWS[i].xr, ROWS[i].xm});
            chk(c.snoop_active, 1'b1);
            if (ROWS[i].lin) chk(c.lin_range, LIN_MAX);
        end
        ms <= LVL_FLOAT;
        do_reset();
        chk(c.op_mode, MODE_REGISTER);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(rd, CTRL_RESET);
        apb(1'b0, 8'h18, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0000_0000);
        apb(1'b1, ADDR_SLEW, 32'h0000_7653);
        apb(1'b1, ADDR_SWG14, 32'h0000_1234);
        apb(1'b1, ADDR_SWG20, 32'h0000_5678);
        apb(1'b1, ADDR_LIN, 32'h0000_0001);
        wt(2);
        chk({c.edge_rate_clk, c.edge_rate_data}, 6'o35);
        chk(c.lane_swing, 16'h1234);
        chk(c.lin_range, 2'h1);
        eq <= 2'h2;
        snoop(SNOOP_OFS_RATE, 8'h01);
        chk(c.link_gen, GEN_FRL);
        chk({c.emph_data, c.emph_clk}, {DE_3P7, DE_3P7});
        chk(c.lane_swing, 16'h5678);
        eq <= 2'h3;
        wt(2);
        chk(c.emph_data, DE_4P6);
        apb(1'b1, ADDR_CTRL, 32'h0000_0003);
        wt(2);
        chk({c.clk_lane_data3, c.ref_clk_en}, 2'b10);
        pd <= 1'b1;
        wt(3);
        pd <= 1'b0;
        chk(c.link_gen, GEN_14);
        chk({c.ref_clk_en, c.main_clk_en}, 2'b10);
        snoop(SNOOP_OFS_RATIO, 8'h02);
        chk({c.edge_rate_clk, c.edge_rate_data}, 6'o36);
        chk(c.lane_swing, 16'h5678);
        chk({c.ref_clk_en, c.main_clk_en}, 2'b10);
        apb(1'b1, ADDR_CTRL, 32'h0000_003B);
        wt(2);
        chk(c.ref_clk_en, 1'b0);
        chk({c.emph_data, c.emph_clk}, {DE_2P5, EMPH_0DB});
        apb(1'b1, ADDR_CTRL, 32'h0000_0016);
        wt(2);
        chk({c.edge_rate_en, c.emph_data}, {1'b0, EMPH_0DB});
        chk(c.snoop_active, 1'b0);
        snoop(SNOOP_OFS_RATE, 8'h01);
        chk(c.link_gen, GEN_20);
        give_verdict();
    end
endmodule
